//--- ext_int_pkg.sv
// Constants and types for the external interrupt detector
package ext_int_pkg;
    localparam int CLOCKS_PER_MACHINE_CYCLE = 12;
    localparam int PHASE_WIDTH = 4;
    localparam logic [3:0] S5P2_PHASE = 4'h9;
    localparam logic [3:0] LAST_PHASE = 4'(CLOCKS_PER_MACHINE_CYCLE - 1);
    localparam int CALL_MACHINE_CYCLES = 2;
    localparam int CALL_CLOCKS = CALL_MACHINE_CYCLES * CLOCKS_PER_MACHINE_CYCLE;
    localparam int NUM_SOURCES = 8;
    localparam int ADDR_WIDTH = 5;
    // Byte offsets of the register map
    localparam logic [4:0] CONTROL_OFFSET = 5'h00;
    localparam logic [4:0] FLAGS_OFFSET = 5'h04;
    localparam logic [4:0] STATUS_OFFSET = 5'h08;
    localparam logic [4:0] CLEAR_OFFSET = 5'h0c;
    localparam logic [4:0] ENABLE_OFFSET = 5'h10;
    localparam logic [4:0] VECTOR_OFFSET = 5'h14;
    // Control register bit positions
    localparam int EXT0_TRIGGER_TYPE_BIT = 0;
    localparam int EXT1_TRIGGER_TYPE_BIT = 1;
    localparam int EXT2_RISING_SELECT_BIT = 2;
    localparam int EXT3_RISING_SELECT_BIT = 3;
    localparam int TIMER2_EXT_TRIGGER_ENABLE_BIT = 4;
    localparam int CONTROL_WIDTH = 5;
    // Source numbering: 0,1 level/falling, 2..6 edge pins, 7 timer-2 trigger
    localparam int TIMER2_SOURCE = 7;
    localparam logic [4:0] CONTROL_RESET = 5'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    // Inactive pin levels: high for falling-edge inputs, low for rising
    localparam logic [7:0] PREV_SAMPLE_RESET = 8'h8f;
    localparam logic [7:0] SYNC_RESET = 8'h8f;

    typedef enum logic [2:0] {
        VEC_IDLE = 3'b001,
        VEC_CALL1 = 3'b010,
        VEC_CALL2 = 3'b100
    } vector_state_type;
endpackage : ext_int_pkg

//--- external_interrupt_detect.sv
// External interrupt request detection, flagging and vectoring timing
`timescale 1ns/10ps
module external_interrupt_detect
    import ext_int_pkg::*;
#(
    parameter int MC_CLOCKS = CLOCKS_PER_MACHINE_CYCLE
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [1:0] ext_request_pin_n,
    input wire logic [6:2] ext_edge_pin,
    input wire logic timer2_ext_trigger_pin,
    input wire logic instr_final,
    input wire logic instr_blocks_vector,
    input wire logic return_from_interrupt,
    input wire logic [7:0] priority_block,
    input wire logic [ADDR_WIDTH-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic irq,
    output logic call_active,
    output logic [2:0] call_source,
    output logic service_start
);
    localparam int CALL_TAIL = CALL_MACHINE_CYCLES * MC_CLOCKS - 8;

    typedef struct packed {
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] prev;
        logic [3:0] phase;
        logic [7:0] flags;
        logic [7:0] polled;
        logic [4:0] ctrl;
        logic [7:0] status;
        logic [7:0] enable;
        logic defer;
        logic in_progress;
        vector_state_type vstate;
        logic call_active;
        logic [2:0] call_source;
        logic service_start;
        logic waitrequest;
        logic [31:0] readdata;
        logic irq;
    } state_type;

    localparam state_type STATE_RESET = '{
        sync1: SYNC_RESET,
        sync2: SYNC_RESET,
        prev: PREV_SAMPLE_RESET,
        phase: 4'h0,
        flags: FLAGS_RESET,
        polled: 8'h00,
        ctrl: CONTROL_RESET,
        status: STATUS_RESET,
        enable: ENABLE_RESET,
        defer: 1'b0,
        in_progress: 1'b0,
        vstate: VEC_IDLE,
        call_active: 1'b0,
        call_source: 3'h0,
        service_start: 1'b0,
        waitrequest: 1'b1,
        readdata: 32'h0000_0000,
        irq: 1'b0
    };

    state_type s;
    state_type n;
    logic [7:0] pins;
    logic [7:0] set_req;
    logic [7:0] level_val;
    logic [7:0] clr_mask;
    logic [7:0] pending;
    logic call_start;
    logic [2:0] pick;
    logic at_s5p2;
    logic at_last;
    logic bus_take;
    logic [3:0] last_phase;

    assign pins = {timer2_ext_trigger_pin, ext_edge_pin, ext_request_pin_n};

    always_comb begin
        n = s;
        set_req = 8'h00;
        level_val = 8'h00;
        clr_mask = 8'h00;
        pending = 8'h00;
        call_start = 1'b0;
        pick = 3'h0;
        last_phase = 4'(MC_CLOCKS - 1);
        at_s5p2 = (s.phase == S5P2_PHASE);
        at_last = (s.phase == last_phase);
        bus_take = (read || write) && !s.waitrequest;

        // Two-stage synchroniser for all request pins
        n.sync1 = pins;
        n.sync2 = s.sync1;
        n.phase = at_last ? 4'h0 : s.phase + 4'h1;

        // Edge detection on the S5P2 sample of each machine cycle
        if (at_s5p2) begin
            n.prev = s.sync2;
            for (int i = 0; i < 2; i++) begin
                level_val[i] = !s.sync2[i];
                set_req[i] = s.prev[i] && !s.sync2[i];
            end
            for (int i = 2; i < 4; i++) begin
                if (s.ctrl[EXT2_RISING_SELECT_BIT + i - 2]) begin
                    set_req[i] = !s.prev[i] && s.sync2[i];
                end else begin
                    set_req[i] = s.prev[i] && !s.sync2[i];
                end
            end
            for (int i = 4; i < 7; i++) begin
                set_req[i] = !s.prev[i] && s.sync2[i];
            end
            set_req[TIMER2_SOURCE] = s.ctrl[TIMER2_EXT_TRIGGER_ENABLE_BIT]
                && s.prev[TIMER2_SOURCE] && !s.sync2[TIMER2_SOURCE];
        end

        // Snapshot at the start of the cycle after S5P2; only this is polled
        if (s.phase == 4'h0) begin
            n.polled = s.flags;
        end

        // Blocked requests are dropped, nothing pends beyond the flag
        pending = s.polled & ~priority_block;
        for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
            if (pending[i]) begin
                pick = 3'(i);
            end
        end
        // Vector only in the final cycle of an unblocked instruction
        call_start = at_last && (s.vstate == VEC_IDLE) && !s.in_progress
            && (pending != 8'h00) && instr_final
            && !instr_blocks_vector && !s.defer;

        if (at_last && instr_final) begin
            n.defer = instr_blocks_vector;
        end

        if (call_start) begin
            clr_mask[pick] = 1'b1;
            if (pick < 3'h2 && !s.ctrl[pick[0]]) begin
                clr_mask[pick] = 1'b0;
            end
        end

        // Level inputs follow the pin; edge flags are sticky until vectored
        for (int i = 0; i < NUM_SOURCES; i++) begin
            n.flags[i] = (s.flags[i] && !clr_mask[i]) || set_req[i];
        end
        // Separate loop so no index runs past the five control bits
        for (int i = 0; i < 2; i++) begin
            if (!s.ctrl[i]) begin
                n.flags[i] = at_s5p2 ? level_val[i] : s.flags[i];
            end
        end

        // Two machine-cycle hardware call, then the routine starts
        n.service_start = 1'b0;
        unique case (s.vstate)
            VEC_IDLE: begin
                if (call_start) begin
                    n.vstate = VEC_CALL1;
                    n.call_active = 1'b1;
                    n.call_source = pick;
                    n.in_progress = 1'b1;
                end
            end
            VEC_CALL1: begin
                if (at_last) begin
                    n.vstate = VEC_CALL2;
                end
            end
            VEC_CALL2: begin
                if (at_last) begin
                    n.vstate = VEC_IDLE;
                    n.call_active = 1'b0;
                    n.service_start = 1'b1;
                end
            end
        endcase
        if (return_from_interrupt && s.vstate == VEC_IDLE) begin
            n.in_progress = 1'b0;
        end

        // Bus slave: one wait cycle, then accept at the waitrequest-low edge
        n.waitrequest = !((read || write) && s.waitrequest);
        n.readdata = 32'h0000_0000;
        if (read && s.waitrequest) begin
            unique case (address)
                CONTROL_OFFSET: n.readdata = {27'h0, s.ctrl};
                FLAGS_OFFSET: n.readdata = {24'h0, s.flags};
                STATUS_OFFSET: n.readdata = {24'h0, s.status};
                ENABLE_OFFSET: n.readdata = {24'h0, s.enable};
                VECTOR_OFFSET: n.readdata = {27'h0, s.in_progress, s.call_active,
                    s.call_source == 3'h7, s.defer, s.service_start};
                default: n.readdata = 32'h0000_0000;
            endcase
        end else if (bus_take) begin
            n.readdata = s.readdata;
        end

        // Sticky event status; a new event beats a simultaneous clear
        if (write && bus_take && byteenable[0]) begin
            unique case (address)
                CONTROL_OFFSET: n.ctrl = writedata[CONTROL_WIDTH-1:0];
                CLEAR_OFFSET: n.status = s.status & ~writedata[7:0];
                ENABLE_OFFSET: n.enable = writedata[7:0];
                default: n.status = s.status;
            endcase
        end
        n.status = n.status | (n.flags & ~s.flags);
        n.irq = (n.status & n.enable) != 8'h00;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s <= STATE_RESET;
        end else begin
            s <= n;
        end
    end

    assign readdata = s.readdata;
    assign waitrequest = s.waitrequest;
    assign irq = s.irq;
    assign call_active = s.call_active;
    assign call_source = s.call_source;
    assign service_start = s.service_start;

    default clocking main_clk @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    sequence call_begins;
        call_start ##1 call_active;
    endsequence

    sequence call_runs;
        call_active [*8] ##CALL_TAIL call_active ##1 !call_active;
    endsequence

    AST_CALL_LENGTH: assert property (call_begins |-> ##0 call_runs)
        else $error("Hardware call did not last two machine cycles");

    AST_SERVICE_AFTER_CALL: assert property ($fell(call_active) |-> service_start)
        else $error("Service start did not follow the call");

    AST_FALLING_SAMPLE: assert property (at_s5p2 && s.ctrl[0] && s.prev[0]
        && !s.sync2[0] |=> s.flags[0])
        else $error("Falling edge on input 0 missed");

    AST_LEVEL_FOLLOWS: assert property (at_s5p2 && !s.ctrl[1] && !$past(call_start)
        |=> s.flags[1] == !$past(s.sync2[1]))
        else $error("Level flag does not follow the pin");

    AST_RISING_HIGH: assert property (at_s5p2 && !s.prev[5] && s.sync2[5] |=> s.flags[5])
        else $error("Rising edge on input 5 missed");

    AST_POLARITY: assert property (at_s5p2 && s.ctrl[EXT3_RISING_SELECT_BIT]
        && s.prev[3] && !s.sync2[3] && !s.flags[3] |=> !s.flags[3])
        else $error("Falling edge set a rising-selected flag");

    AST_TIMER2_GATED: assert property (!s.ctrl[TIMER2_EXT_TRIGGER_ENABLE_BIT]
        && !s.flags[TIMER2_SOURCE] |=> !s.flags[TIMER2_SOURCE])
        else $error("Timer-2 flag set while trigger disabled");

    AST_SET_AT_S5P2: assert property ((s.flags & ~$past(s.flags)) != 8'h00
        |-> $past(s.phase) == S5P2_PHASE)
        else $error("Request flag rose outside S5P2");

    AST_CALL_UNBLOCKED: assert property (call_start |-> instr_final
        && !instr_blocks_vector && !s.defer && !s.in_progress)
        else $error("Call made while vectoring was blocked");

    AST_CLEARED_ON_CALL: assert property (call_start && pick > 3'h1 && !at_s5p2
        |=> !s.flags[s.call_source])
        else $error("Edge flag not cleared by the call");

    AST_ONLY_POLLED: assert property (call_start |-> s.polled[pick]
        && !priority_block[pick])
        else $error("Call for a source not pending this poll");
endmodule : external_interrupt_detect

//--- ext_pin_source.sv
// Model of the external request sources that drive the interrupt pins
`timescale 1ns/10ps
module ext_pin_source
    import ext_int_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [7:0] target,
    output logic [7:0] pins
);
    logic [7:0] hold_count;
    // A level moves only after the last one stood a full machine cycle
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pins <= PREV_SAMPLE_RESET;
            hold_count <= 8'h00;
        end else if (target != pins && hold_count >= 8'(CLOCKS_PER_MACHINE_CYCLE)) begin
            pins <= target;
            hold_count <= 8'h00;
        end else if (hold_count != 8'hff) begin
            hold_count <= hold_count + 8'h01;
        end
    end
endmodule : ext_pin_source

//--- external_interrupt_detect_tb.sv
// Self-checking bench for the external interrupt detector
`timescale 1ns/10ps
module external_interrupt_detect_tb
    import ext_int_pkg::*;
;
    localparam int MC = CLOCKS_PER_MACHINE_CYCLE;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] target, pins, priority_block, ef, es, old, nw;
    logic instr_final, instr_blocks_vector, rfi, read, write, waitrequest, irq;
    logic call_active, service_start;
    logic [4:0] address, ctrl;
    logic [31:0] writedata, readdata, q;
    logic [3:0] byteenable;
    logic [2:0] call_source;
    int bad_count = 0;
    int compares = 0;
    int calls = 0;
    int n;
    always #4 mclk = ~mclk;
    ext_pin_source src (.mclk(mclk), .resetn(resetn), .target(target), .pins(pins));
    external_interrupt_detect #(.MC_CLOCKS(MC)) uut (.mclk(mclk), .resetn(resetn),
        .ext_request_pin_n(pins[1:0]), .ext_edge_pin(pins[6:2]),
        .timer2_ext_trigger_pin(pins[7]), .instr_final(instr_final),
        .instr_blocks_vector(instr_blocks_vector), .return_from_interrupt(rfi),
        .priority_block(priority_block), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq), .call_active(call_active),
        .call_source(call_source), .service_start(service_start));
    task automatic stop_test();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        @(posedge mclk);
        while (waitrequest !== 1'b0) begin
            @(posedge mclk);
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic rd_chk(input string what, input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(what, exp, q);
    endtask : rd_chk
    // Counts routine starts while time passes
    task automatic wait_mc(input int k);
        repeat (k * MC) begin
            @(posedge mclk);
            if (service_start === 1'b1) calls++;
        end
    endtask : wait_mc
    task automatic do_reset();
        resetn <= 1'b0;
        target <= PREV_SAMPLE_RESET;
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
    endtask : do_reset
    function automatic logic [7:0] next_flags(logic [7:0] f, logic [7:0] o, logic [7:0] v,
                                              logic [4:0] c);
        logic [7:0] r, fall, rise;
        fall = o & ~v;
        rise = ~o & v;
        r = f;
        for (int i = 0; i < 2; i++) r[i] = c[i] ? (f[i] | fall[i]) : ~v[i];
        r[2] = f[2] | (c[2] ? rise[2] : fall[2]);
        r[3] = f[3] | (c[3] ? rise[3] : fall[3]);
        r[6:4] = f[6:4] | rise[6:4];
        r[7] = f[7] | (c[4] & fall[7]);
        return r;
    endfunction : next_flags
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        stop_test();
    end
    initial begin
        {instr_final, instr_blocks_vector, rfi, read, write} = 5'h00;
        {priority_block, address, writedata, byteenable} = '0;
        target = PREV_SAMPLE_RESET;
        n = $urandom(1809);
        byteenable = 4'hf;
        // No vectoring: flags keep what the pins did
        for (int r = 0; r < 3; r++) begin
            ctrl = (r == 0) ? 5'h00 : (r == 1) ? 5'h1f : 5'($urandom);
            do_reset();
            rd_chk("flags_reset", FLAGS_OFFSET, 32'h0);
            rd_chk("unmapped", 5'h1c, 32'h0);
            bus(1'b1, CONTROL_OFFSET, {27'h0, ctrl});
            rd_chk("control", CONTROL_OFFSET, {27'h0, ctrl});
            ef = 8'h00;
            es = 8'h00;
            old = PREV_SAMPLE_RESET;
            for (int s = 0; s < 8; s++) begin
                nw = (s == 0) ? ~old : 8'($urandom);
                target <= nw;
                repeat (4 * MC) @(posedge mclk);
                nw = next_flags(ef, old, nw, ctrl);
                es = es | (nw & ~ef);
                ef = nw;
                old = pins;
                rd_chk("flags", FLAGS_OFFSET, {24'h0, ef});
            end
            rd_chk("status", STATUS_OFFSET, {24'h0, es});
            bus(1'b1, ENABLE_OFFSET, {24'h0, es});
            rd_chk("enable", ENABLE_OFFSET, {24'h0, es});
            check("irq_on", {31'h0, es != 8'h00}, {31'h0, irq});
            bus(1'b1, CLEAR_OFFSET, 32'hff);
            rd_chk("status_clr", STATUS_OFFSET, 32'h0);
            check("irq_off", 32'h0, {31'h0, irq});
        end
        // Edge on input 0 is vectored within the response bounds
        do_reset();
        instr_final <= 1'b1;
        bus(1'b1, CONTROL_OFFSET, 32'h1);
        target <= 8'h8e;
        n = 0;
        calls = 0;
        while (service_start !== 1'b1 && n < 20 * MC) begin
            @(posedge mclk);
            n++;
            if (call_active === 1'b1) calls++;
        end
        check("call_length", CALL_CLOCKS, calls);
        check("latency", 32'h1, {31'h0, n > 3 * MC && n < 9 * MC});
        check("source", 32'h0, {29'h0, call_source});
        rd_chk("flag_cleared", FLAGS_OFFSET, 32'h0);
        rfi <= 1'b1;
        @(posedge mclk);
        rfi <= 1'b0;
        // Release pin 0 first, or level mode would see it low and vector
        target <= 8'h8f;
        wait_mc(2);
        // Blocked level request that goes away is forgotten
        bus(1'b1, CONTROL_OFFSET, 32'h0);
        calls = 0;
        priority_block <= 8'h02;
        target <= 8'h8d;
        wait_mc(4);
        target <= 8'h8f;
        wait_mc(2);
        priority_block <= 8'h00;
        wait_mc(4);
        check("blocked_calls", 32'h0, calls);
        // Level request held through the call; flag follows the pin
        target <= 8'h8d;
        wait_mc(8);
        check("level_calls", 32'h1, calls);
        rd_chk("level_flag", FLAGS_OFFSET, 32'h02);
        rd_chk("vector", VECTOR_OFFSET, 32'h10);
        target <= 8'h8f;
        wait_mc(2);
        rfi <= 1'b1;
        @(posedge mclk);
        rfi <= 1'b0;
        wait_mc(4);
        check("no_repeat", 32'h1, calls);
        // Blocking instruction ends hold vectoring back one more instruction
        instr_blocks_vector <= 1'b1;
        target <= 8'h8d;
        wait_mc(4);
        check("deferred_calls", 32'h1, calls);
        instr_blocks_vector <= 1'b0;
        wait_mc(5);
        check("released_calls", 32'h2, calls);
        stop_test();
    end
endmodule : external_interrupt_detect_tb
